// ### ueb_consts.svh
// offsets, field positions, reset values and counts of the receive error and baud block
// Overview of operation
// - error status resets zero, software reads only
// - bit 2 flags received parity mismatch
// - bit 1 flags missing stop bit
// - bit 0 flags frame done while buffer unread
// - only first stop bit is checked
// - overrun repeats while buffer stays unread
// - baud control resets zero, byte writes only
// - upper nibble picks fx/2^(n+2) source, lower zero
// - code 1000 routes external clock pin
// - internal baud is fx/2^(n+2)/8
// - external baud is pin clock/16
// - buffer read clears flags, next frame rewrites them
// - falling line resampled at half bit
`ifndef UEB_CONSTS_SVH
`define UEB_CONSTS_SVH
`define UEB_ADDR_STATUS  16'hff71
`define UEB_ADDR_BAUD    16'hff73
`define UEB_STATUS_RESET 3'h0
`define UEB_BAUD_RESET   8'h00
`define UEB_BIT_OVERRUN  0
`define UEB_BIT_FRAMING  1
`define UEB_BIT_PARITY   2
`define UEB_SEL_EXT      4'h8
`define UEB_HALF_BIT     3'h3
`define UEB_FULL_BIT     3'h7
`define UEB_PAR_NONE     2'h0
`define UEB_PAR_ZERO     2'h1
`define UEB_PAR_ODD      2'h2
`define UEB_PAR_EVEN     2'h3
`endif

// ### ueb_pkg.sv
// types of the receive error and baud block
package ueb_pkg;
   typedef enum logic [4:0] {
      S_IDLE  = 5'h01,
      S_START = 5'h02,
      S_DATA  = 5'h04,
      S_PAR   = 5'h08,
      S_STOP  = 5'h10
   } ueb_rx_state_t;

   // async mode settings held by the mode register elsewhere
   typedef struct packed {
      logic       rx_en;
      logic [1:0] parity;
      logic       char8;
      logic       stop_length_select;
   } ueb_mode_t;

   typedef struct packed {
      ueb_rx_state_t fsm;
      logic [7:0]    baud;
      logic [2:0]    flags;
      logic          full;
      logic [7:0]    shift;
      logic [7:0]    rxbuf;
      logic [2:0]    sub;
      logic [2:0]    nbit;
      logic          par_bit;
      logic [9:0]    pre;
      logic          ext_half;
      logic [1:0]    rx_sync;
      logic          rx_prev;
      logic [1:0]    ck_sync;
      logic          ck_prev;
      logic [7:0]    rdata;
      logic          done;
   } ueb_state_t;
endpackage

// ### ueb_uart_err_baud.sv
// receive error status, baud source control and the receiver that feeds them
`timescale 1ns/1ps
`default_nettype none
`include "ueb_consts.svh"

module ueb_uart_err_baud (
   // clock and reset
   input  wire logic             i_ref_clk,
   input  wire logic             i_arst_n,
   // memory access port
   input  wire logic [15:0]      i_addr,
   input  wire logic             i_wr,
   input  wire logic             i_rd,
   input  wire logic             i_bit_op,
   input  wire logic [7:0]       i_wdata,
   output logic      [7:0]       o_rdata,
   // mode settings and receive buffer
   input  wire ueb_pkg::ueb_mode_t i_mode,
   input  wire logic             i_rxbuf_rd,
   output logic      [7:0]       o_receive_buffer,
   output logic                  o_rx_done,
   // pins
   input  wire logic             i_rxd,
   input  wire logic             i_external_baud_clock_pin
);

   ueb_pkg::ueb_state_t s;
   ueb_pkg::ueb_state_t next_s;

   logic       ext_sel;
   logic       int_sel;
   logic [9:0] mask;
   logic       ck_rise;
   logic       sub_tick;
   logic       rx;
   logic       full_bit;
   logic [7:0] data;
   logic       ones_odd;

   // ********************************************
   // baud source
   // ********************************************
   always_comb begin
      ext_sel  = (s.baud[7:4] == `UEB_SEL_EXT);
      int_sel  = ~s.baud[7];
      mask     = (10'h004 << s.baud[6:4]) - 10'h001;
      ck_rise  = s.ck_sync[1] & ~s.ck_prev;
      // prohibited codes give no ticks at all
      sub_tick = (ext_sel & ck_rise & s.ext_half)
               | (int_sel & ((s.pre & mask) == mask));
      rx       = s.rx_sync[1];
      full_bit = sub_tick & (s.sub == `UEB_FULL_BIT);
      data     = i_mode.char8 ? s.shift : {1'b0, s.shift[7:1]};
      ones_odd = ^{data, s.par_bit};
   end

   // ********************************************
   // next state
   // ********************************************
   always_comb begin
      next_s            = s;
      next_s.done       = 1'b0;
      next_s.pre        = s.pre + 10'h001;
      next_s.rx_sync    = {s.rx_sync[0], i_rxd};
      next_s.rx_prev    = s.rx_sync[1];
      next_s.ck_sync    = {s.ck_sync[0], i_external_baud_clock_pin};
      next_s.ck_prev    = s.ck_sync[1];
      if (ck_rise) begin
         next_s.ext_half = ~s.ext_half;
      end

      // register port; a bit write to baud control is dropped
      if (i_wr && !i_bit_op && i_addr == `UEB_ADDR_BAUD) begin
         next_s.baud = {i_wdata[7:4], 4'h0};
      end
      if (i_rd) begin
         if (i_addr == `UEB_ADDR_STATUS) begin
            next_s.rdata = {5'h00, s.flags};
         end else if (i_addr == `UEB_ADDR_BAUD) begin
            next_s.rdata = s.baud;
         end else begin
            next_s.rdata = 8'h00;
         end
      end

      // buffer read empties it; a completing frame below overrides
      if (i_rxbuf_rd) begin
         next_s.full  = 1'b0;
         next_s.flags = 3'h0;
      end

      if (sub_tick) begin
         next_s.sub = s.sub + 3'h1;
      end

      case (s.fsm)
         ueb_pkg::S_IDLE: begin
            if (s.rx_prev && !rx) begin
               next_s.fsm = ueb_pkg::S_START;
               next_s.sub = 3'h0;
            end
         end
         ueb_pkg::S_START: begin
            if (sub_tick && s.sub == `UEB_HALF_BIT) begin
               next_s.sub  = 3'h0;
               next_s.nbit = 3'h0;
               // a glitch shorter than half a bit is dropped
               next_s.fsm  = rx ? ueb_pkg::S_IDLE : ueb_pkg::S_DATA;
            end
         end
         ueb_pkg::S_DATA: begin
            if (full_bit) begin
               next_s.shift = {rx, s.shift[7:1]};
               next_s.nbit  = s.nbit + 3'h1;
               if (s.nbit == (i_mode.char8 ? 3'h7 : 3'h6)) begin
                  next_s.fsm = (i_mode.parity == `UEB_PAR_NONE) ?
                               ueb_pkg::S_STOP : ueb_pkg::S_PAR;
               end
            end
         end
         ueb_pkg::S_PAR: begin
            if (full_bit) begin
               next_s.par_bit = rx;
               next_s.fsm     = ueb_pkg::S_STOP;
            end
         end
         ueb_pkg::S_STOP: begin
            // one stop bit ends the frame whatever the stop length
            if (full_bit) begin
               next_s.fsm   = ueb_pkg::S_IDLE;
               next_s.rxbuf = data;
               next_s.done  = 1'b1;
               next_s.full  = 1'b1;
               next_s.flags[`UEB_BIT_PARITY] =
                  (i_mode.parity == `UEB_PAR_ODD  && !ones_odd) ||
                  (i_mode.parity == `UEB_PAR_EVEN &&  ones_odd);
               next_s.flags[`UEB_BIT_FRAMING] = ~rx;
               next_s.flags[`UEB_BIT_OVERRUN] =
                  s.full & ~i_rxbuf_rd;
            end
         end
         default: begin
            next_s.fsm = ueb_pkg::S_IDLE;
         end
      endcase

      // disabling stops reception at once and leaves buffer and flags
      if (!i_mode.rx_en) begin
         next_s.fsm  = ueb_pkg::S_IDLE;
         next_s.done = 1'b0;
         if (s.fsm == ueb_pkg::S_STOP) begin
            next_s.rxbuf = s.rxbuf;
            next_s.full  = i_rxbuf_rd ? 1'b0 : s.full;
            next_s.flags = i_rxbuf_rd ? 3'h0 : s.flags;
         end
      end
   end

   // ********************************************
   // state register
   // ********************************************
   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         s       <= '0;
         s.fsm   <= ueb_pkg::S_IDLE;
         s.baud  <= `UEB_BAUD_RESET;
         s.flags <= `UEB_STATUS_RESET;
      end else begin
         s <= next_s;
      end
   end

   assign o_rdata          = s.rdata;
   assign o_receive_buffer = s.rxbuf;
   assign o_rx_done        = s.done;

   // ********************************************
   // checks
   // ********************************************
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (!i_arst_n);

   AST_STATUS_READ: assert property (
      (i_rd && i_addr == `UEB_ADDR_STATUS)
      |=> (o_rdata == {5'h00, $past(s.flags)}))
      else $error("status read returns wrong value");

   AST_STATUS_NO_WRITE: assert property (
      (i_wr && i_addr == `UEB_ADDR_STATUS && !next_s.done && !i_rxbuf_rd)
      |=> $stable(s.flags))
      else $error("status changed by a write");

   AST_PARITY_OFF: assert property (
      (s.done && $past(i_mode.parity) inside {`UEB_PAR_NONE, `UEB_PAR_ZERO})
      |-> !s.flags[`UEB_BIT_PARITY])
      else $error("parity flag without parity check");

   AST_FRAMING: assert property (
      s.done |-> (s.flags[`UEB_BIT_FRAMING] == !$past(s.rx_sync[1])))
      else $error("framing flag does not follow stop bit");

   AST_OVERRUN: assert property (
      s.done |-> (s.flags[`UEB_BIT_OVERRUN] == $past(s.full && !i_rxbuf_rd)))
      else $error("overrun flag does not follow buffer state");

   AST_BUF_READ_CLEARS: assert property (
      (i_rxbuf_rd && !next_s.done) |=> (s.flags == 3'h0 && !s.full))
      else $error("buffer read did not clear flags");

   AST_BAUD_BYTE_ONLY: assert property (
      (i_wr && i_bit_op) |=> $stable(s.baud))
      else $error("bit write changed baud control");

   AST_BAUD_LOW_ZERO: assert property (
      s.baud[3:0] == 4'h0)
      else $error("baud control low nibble not zero");

   AST_FLAGS_WITH_BUF: assert property (
      !$stable(s.flags) |-> (s.done || $past(i_rxbuf_rd)))
      else $error("flags changed outside buffer transfer or read");

   AST_START_REJECT: assert property (
      (s.fsm == ueb_pkg::S_START && sub_tick && s.sub == `UEB_HALF_BIT && rx && i_mode.rx_en)
      |=> (s.fsm == ueb_pkg::S_IDLE))
      else $error("high line at half bit accepted as start");

   AST_START_ACCEPT: assert property (
      (s.fsm == ueb_pkg::S_START && sub_tick && s.sub == `UEB_HALF_BIT && !rx && i_mode.rx_en)
      |=> (s.fsm == ueb_pkg::S_DATA))
      else $error("low line at half bit not accepted as start");

   AST_DONE_PULSE: assert property (
      o_rx_done |=> !o_rx_done)
      else $error("completion pulse longer than one cycle");

   AST_DONE_FILLS_BUF: assert property (
      o_rx_done |-> (s.full && o_receive_buffer == $past(data)))
      else $error("buffer not filled with completing frame");

   AST_DONE_FROM_STOP: assert property (
      o_rx_done |-> ($past(s.fsm) == ueb_pkg::S_STOP))
      else $error("frame completed outside the stop bit");

   AST_ONE_STOP: assert property (
      (s.fsm == ueb_pkg::S_STOP && full_bit && i_mode.rx_en)
      |=> (s.fsm == ueb_pkg::S_IDLE && o_rx_done))
      else $error("receiver waited for a second stop bit");

   AST_PARITY_ODD: assert property (
      (o_rx_done && $past(i_mode.parity) == `UEB_PAR_ODD)
      |-> (s.flags[`UEB_BIT_PARITY] == !$past(ones_odd)))
      else $error("odd parity flag wrong");

   AST_PARITY_EVEN: assert property (
      (o_rx_done && $past(i_mode.parity) == `UEB_PAR_EVEN)
      |-> (s.flags[`UEB_BIT_PARITY] == $past(ones_odd)))
      else $error("even parity flag wrong");

   AST_OVERRUN_REPEATS: assert property (
      (s.full && s.fsm == ueb_pkg::S_STOP && full_bit && !i_rxbuf_rd && i_mode.rx_en)
      |=> s.flags[`UEB_BIT_OVERRUN])
      else $error("overrun not raised again on unread buffer");

   AST_BAUD_WRITE: assert property (
      (i_wr && !i_bit_op && i_addr == `UEB_ADDR_BAUD)
      |=> (s.baud == {$past(i_wdata[7:4]), 4'h0}))
      else $error("byte write to baud control not taken");

   AST_BAUD_READ: assert property (
      (i_rd && i_addr == `UEB_ADDR_BAUD) |=> (o_rdata == $past(s.baud)))
      else $error("baud control read returns wrong value");

   AST_OTHER_READ_ZERO: assert property (
      (i_rd && i_addr != `UEB_ADDR_BAUD && i_addr != `UEB_ADDR_STATUS) |=> (o_rdata == 8'h00))
      else $error("unmapped read not zero");

   AST_PROHIBITED_NO_TICK: assert property (
      (s.baud[7] && s.baud[7:4] != `UEB_SEL_EXT) |-> !sub_tick)
      else $error("prohibited source code still ticks");

   AST_EXT_TICK_ON_EDGE: assert property (
      (s.baud[7:4] == `UEB_SEL_EXT && sub_tick) |-> (ck_rise && s.ext_half))
      else $error("external tick without every second pin edge");

   AST_FAST_TICK_SPACING: assert property (
      (s.baud[7:4] == 4'h0 && sub_tick)
      |=> (!sub_tick || s.baud[7:4] != 4'h0) [*3])
      else $error("fastest internal tick closer than four clocks");

   AST_EXT_NO_PRESCALE: assert property (
      (s.baud[7:4] == `UEB_SEL_EXT && !ck_rise) |-> !sub_tick)
      else $error("prescaler ticks while external source selected");

   AST_STATUS_HIGH_ZERO: assert property (
      (i_rd && i_addr == `UEB_ADDR_STATUS) |=> (o_rdata[7:3] == 5'h00))
      else $error("unused status bits not zero");

endmodule // ueb_uart_err_baud
`default_nettype wire

// ### ueb_tx_model.sv
// remote serial transmitter model driving the receive pin and the external baud clock
`timescale 1ns/1ps
`default_nettype none
module ueb_tx_model (
   // clock
   input  wire logic i_ref_clk,
   // pins
   output logic      o_rxd,
   output logic      o_ext_clk
);
   int unsigned cnt = 0;
   initial begin
      o_rxd = 1'b1;
      o_ext_clk = 1'b0;
   end
   // one bit held for bp clocks; the external clock toggles every fourth clock while ext is set, gap bits included
   task automatic put(input logic b, input int bp, input logic ext);
      o_rxd = b;
      repeat (bp) begin
         @(negedge i_ref_clk);
         cnt++;
         if (ext && cnt % 4 == 0) o_ext_clk = ~o_ext_clk;
      end
   endtask
   // start, eight data bits lsb first, parity, one stop, then gap idle bits
   task automatic send(input logic [7:0] d, input logic pb, input logic stp, input int bp, input logic ext,
                       input int gap);
      put(1'b0, bp, ext);
      for (int k = 0; k < 8; k++) put(d[k], bp, ext);
      put(pb, bp, ext);
      put(stp, bp, ext);
      repeat (gap) put(1'b1, bp, ext);
   endtask
endmodule // ueb_tx_model
`default_nettype wire

// ### uart_error_status_baud_gen_bench.sv
// self-checking bench of the receive error status and baud source block
`timescale 1ns/1ps
`default_nettype none
`include "ueb_consts.svh"
module uart_error_status_baud_gen_bench;
   logic clk = 1'b0, arst_n = 1'b0, wr = 1'b0, rd = 1'b0, bop = 1'b0, bufrd = 1'b0, done_seen = 1'b0;
   logic [15:0] addr = 16'h0000;
   logic [7:0] wdata = 8'h00, rdata, rbuf;
   logic rx_done, rxd, ext;
   ueb_pkg::ueb_mode_t mode = '{1'b1, `UEB_PAR_EVEN, 1'b1, 1'b1};
   int bad_count = 0, n_checks = 0;
   always #25 clk = ~clk;
   always @(posedge clk) if (rx_done === 1'b1) done_seen <= 1'b1;
   ueb_uart_err_baud ueb_uart_err_baud_i (.i_ref_clk(clk), .i_arst_n(arst_n), .i_addr(addr), .i_wr(wr),
      .i_rd(rd), .i_bit_op(bop), .i_wdata(wdata), .o_rdata(rdata), .i_mode(mode), .i_rxbuf_rd(bufrd),
      .o_receive_buffer(rbuf), .o_rx_done(rx_done), .i_rxd(rxd), .i_external_baud_clock_pin(ext));
   ueb_tx_model ueb_tx_model_i (.i_ref_clk(clk), .o_rxd(rxd), .o_ext_clk(ext));
   // ****************
   // helpers
   // ****************
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic acc(input logic [15:0] a, input logic w, input logic b, input logic [7:0] d);
      @(negedge clk);
      addr = a;
      wr = w;
      rd = ~w;
      bop = b;
      wdata = d;
      @(negedge clk);
      wr = 1'b0;
      rd = 1'b0;
      @(negedge clk);
   endtask
   task automatic rdc(input logic [15:0] a, input logic [7:0] exp);
      acc(a, 1'b0, 1'b0, 8'h00);
      chk(rdata, exp);
   endtask
   task automatic buf_read;
      @(negedge clk);
      bufrd = 1'b1;
      @(negedge clk);
      bufrd = 1'b0;
   endtask
   // frame sent whole; completion pulse must have been seen by its end
   task automatic frame(input logic [7:0] d, input logic pb, input logic stp, input int bp, input logic ext);
      done_seen = 1'b0;
      ueb_tx_model_i.send(d, pb, stp, bp, ext, 1);
      chk({7'h00, done_seen}, 8'h01);
   endtask
   // ****************
   // scenarios
   // ****************
   task automatic t_regs;
      rdc(`UEB_ADDR_STATUS, 8'h00);
      rdc(`UEB_ADDR_BAUD, `UEB_BAUD_RESET);
      rdc(16'hff7f, 8'h00);
      acc(`UEB_ADDR_BAUD, 1'b1, 1'b0, 8'h4f);
      rdc(`UEB_ADDR_BAUD, 8'h40);
      acc(`UEB_ADDR_BAUD, 1'b1, 1'b1, 8'h80);
      rdc(`UEB_ADDR_BAUD, 8'h40);
      acc(`UEB_ADDR_STATUS, 1'b1, 1'b0, 8'hff);
      acc(`UEB_ADDR_STATUS, 1'b0, 1'b1, 8'h00);
      chk(rdata, 8'h00);
   endtask
   task automatic t_rx;
      acc(`UEB_ADDR_BAUD, 1'b1, 1'b0, 8'h00);
      done_seen = 1'b0;
      ueb_tx_model_i.put(1'b0, 8, 1'b0);
      ueb_tx_model_i.put(1'b1, 64, 1'b0);
      chk({7'h00, done_seen}, 8'h00);
      frame(8'ha5, ^8'ha5, 1'b1, 32, 1'b0);
      rdc(`UEB_ADDR_STATUS, 8'h00);
      chk(rbuf, 8'ha5);
      ueb_tx_model_i.send(8'h3c, ^8'h3c, 1'b1, 32, 1'b0, 0);
      frame(8'h5a, ~^8'h5a, 1'b1, 32, 1'b0);
      rdc(`UEB_ADDR_STATUS, 8'h05);
      chk(rbuf, 8'h5a);
      frame(8'h0f, ^8'h0f, 1'b0, 32, 1'b0);
      rdc(`UEB_ADDR_STATUS, 8'h03);
      buf_read;
      rdc(`UEB_ADDR_STATUS, 8'h00);
      mode.parity = `UEB_PAR_ZERO;
      frame(8'h5a, ~^8'h5a, 1'b1, 32, 1'b0);
      rdc(`UEB_ADDR_STATUS, 8'h00);
      buf_read;
      mode.parity = `UEB_PAR_ODD;
      frame(8'h5a, ^8'h5a, 1'b1, 32, 1'b0);
      rdc(`UEB_ADDR_STATUS, 8'h04);
      buf_read;
      mode.parity = `UEB_PAR_EVEN;
   endtask
   task automatic t_codes;
      for (int c = 1; c < 4; c++) begin
         acc(`UEB_ADDR_BAUD, 1'b1, 1'b0, 8'(c << 4));
         frame(8'(8'h61 + c), ^(8'(8'h61 + c)), 1'b1, 32 << c, 1'b0);
         chk(rbuf, 8'(8'h61 + c));
         buf_read;
      end
   endtask
   task automatic t_ext;
      acc(`UEB_ADDR_BAUD, 1'b1, 1'b0, 8'h80);
      frame(8'h96, ^8'h96, 1'b1, 128, 1'b1);
      chk(rbuf, 8'h96);
      rdc(`UEB_ADDR_STATUS, 8'h00);
   endtask
   task automatic close_out;
      if (bad_count == 0 && n_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   initial begin
      repeat (16) @(negedge clk);
      arst_n = 1'b1;
      repeat (4) @(negedge clk);
      t_regs;
      t_rx;
      t_codes;
      t_ext;
      close_out;
   end
   // a run of about ten thousand clocks; four times that means a hang
   initial begin
      #2000000;
      bad_count++;
      close_out;
   end
endmodule // uart_error_status_baud_gen_bench
`default_nettype wire
